// ===== include/vism_pkg.sv
`default_nettype none
package vism_pkg;
    localparam int unsigned NUM_LINES = 24;
    localparam int unsigned LVL_W = 2;
    localparam int unsigned LINE_W = 5;
    localparam int unsigned EXT_CH = 8;
    // Vector of line n: upper byte at TOP - 2n, lower byte one above
    localparam logic [15:0] VEC_TOP = 16'hFFFA;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [4:0] LINE_EXT4 = 5'h00;
    localparam logic [4:0] LINE_EXT5 = 5'h01;
    localparam logic [4:0] LINE_EXT26 = 5'h02;
    localparam logic [4:0] LINE_EXT37 = 5'h03;
    localparam logic [4:0] LINE_TMR_LO = 5'h05;
    localparam logic [4:0] LINE_TMR_HI = 5'h06;
    localparam logic [47:0] LEVEL_RST = 48'hFFFF_FFFF_FFFF;

    typedef struct packed {
        logic valid;
        logic [4:0] line;
        logic [1:0] level;
        logic [15:0] vec_upper;
        logic [15:0] vec_lower;
    } vism_req_t;
endpackage
`default_nettype wire

// ===== src/vism_irq_map.sv
`default_nettype none
module vism_irq_map
    import vism_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [vism_pkg::EXT_CH-1:0] i_ext_irq,
    input wire logic i_tmr0_lo_irq,
    input wire logic i_tmr0_hi_irq,
    input wire logic [vism_pkg::NUM_LINES-1:0] i_other_irq,
    input wire logic [2*vism_pkg::NUM_LINES-1:0] i_level_fields,
    output logic [vism_pkg::NUM_LINES-1:0] o_lines,
    output vism_pkg::vism_req_t o_req
);
    import vism_pkg::*;

    logic [NUM_LINES-1:0] lines_d;
    logic [NUM_LINES-1:0] lines_q;
    logic [LVL_W-1:0] line_zero_level_field;
    logic [LVL_W-1:0] line_one_level_field;
    logic [LVL_W-1:0] line_two_level_field;
    logic [LVL_W-1:0] line_five_level_field;
    logic [LVL_W-1:0] line_six_level_field;
    vism_req_t req_d;
    vism_req_t req_q;

    function automatic logic [15:0] vec_upper(input logic [4:0] n);
        vec_upper = VEC_TOP - 16'(n) * VEC_STEP;
    endfunction

    assign line_zero_level_field = i_level_fields[1:0];
    assign line_one_level_field = i_level_fields[3:2];
    assign line_two_level_field = i_level_fields[5:4];
    assign line_five_level_field = i_level_fields[11:10];
    assign line_six_level_field = i_level_fields[13:12];

    always_comb begin
        lines_d = i_other_irq;
        lines_d[LINE_EXT4] = i_ext_irq[4];
        lines_d[LINE_EXT5] = i_ext_irq[5];
        lines_d[LINE_EXT26] = i_ext_irq[2] | i_ext_irq[6];
        lines_d[LINE_EXT37] = i_ext_irq[3] | i_ext_irq[7];
        lines_d[LINE_TMR_LO] = i_tmr0_lo_irq;
        lines_d[LINE_TMR_HI] = i_tmr0_hi_irq;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            lines_q <= '0;
        end else begin
            lines_q <= lines_d;
        end
    end

    // Level 0 is the most urgent; scan upward so lowest line wins ties
    always_comb begin
        logic [LVL_W-1:0] lvl;
        lvl = '0;
        req_d = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            lvl = i_level_fields[2*i +: 2];
            if (lines_q[i] && (!req_d.valid || lvl < req_d.level)) begin
                req_d.valid = 1'b1;
                req_d.line = LINE_W'(i);
                req_d.level = lvl;
            end
        end
        if (req_d.valid) begin
            req_d.vec_upper = vec_upper(req_d.line);
            req_d.vec_lower = vec_upper(req_d.line) + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    assign o_lines = lines_q;
    assign o_req = req_q;

    ext4_map_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_ext_irq[4] |=> o_lines[0])
        else $error("ext channel 4 did not raise line 0");
    ext5_map_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_ext_irq[5] |=> o_lines[1])
        else $error("ext channel 5 did not raise line 1");
    ext26_share_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ext_irq[2] || i_ext_irq[6]) |=> o_lines[2])
        else $error("ext channel 2 or 6 did not raise line 2");
    ext37_share_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !$past(i_srst) |->
        ($past(i_ext_irq[3] || i_ext_irq[7]) == o_lines[3]))
        else $error("line 3 does not follow channels 3 and 7");
    tmr_lo_map_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_tmr0_lo_irq |=> o_lines[5])
        else $error("timer lower half did not raise line 5");
    tmr_hi_map_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_tmr0_hi_irq |=> o_lines[6])
        else $error("timer upper half did not raise line 6");
    line0_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd0) |->
        (o_req.vec_upper == 16'hFFFA && o_req.vec_lower == 16'hFFFB))
        else $error("line 0 vector wrong");
    line6_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd6) |->
        (o_req.vec_upper == 16'hFFEE && o_req.vec_lower == 16'hFFEF))
        else $error("line 6 vector wrong");
    tie_lowest_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ($past(lines_q[0] && lines_q[1]) &&
         $past(i_level_fields[1:0] == i_level_fields[3:2]))
        |-> (o_req.valid && o_req.line != 5'd1))
        else $error("equal-level tie not given to lowest line");
    tie_two_three_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ($past(lines_q[2] && lines_q[3]) &&
         $past(i_level_fields[5:4] == i_level_fields[7:6]))
        |-> (o_req.valid && o_req.line != 5'd3))
        else $error("equal-level tie of lines 2 and 3 wrong");

    // Reset clears both output stages
    reset_clear_a: assert property (@(posedge i_ref_clk)
        i_srst |=> (o_lines == '0 && o_req == '0))
        else $error("outputs not cleared by reset");

    // A request only when some line is pending
    valid_any_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_lines != '0) |=> o_req.valid)
        else $error("pending line gave no request");
    valid_none_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_lines == '0) |=> !o_req.valid)
        else $error("request with no pending line");
    idle_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !o_req.valid |-> (o_req == '0))
        else $error("idle request word not zero");
    vector_pair_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_req.valid |-> (o_req.vec_lower == o_req.vec_upper + 16'h0001))
        else $error("lower vector byte not next to upper");

    // Fixed vectors of the mapped lines
    line1_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd1) |->
        (o_req.vec_upper == 16'hFFF8 && o_req.vec_lower == 16'hFFF9))
        else $error("line 1 vector wrong");
    line2_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd2) |->
        (o_req.vec_upper == 16'hFFF6))
        else $error("line 2 vector wrong");
    line3_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd3) |->
        (o_req.vec_upper == 16'hFFF4 && o_req.vec_lower == 16'hFFF5))
        else $error("line 3 vector wrong");
    line5_vector_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd5) |->
        (o_req.vec_upper == 16'hFFF0 && o_req.vec_lower == 16'hFFF1))
        else $error("line 5 vector wrong");

    // Every line keeps the two-byte vector spacing
    generate
        for (genvar g = 0; g < NUM_LINES; g++) begin : g_vec
            vec_table_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst)
                (o_req.valid && o_req.line == LINE_W'(g)) |->
                (o_req.vec_upper == 16'(32'hFFFA - 2 * g)))
                else $error("vector of a line wrong");
        end
    endgenerate

    // Level reported is the winner's own field
    line0_level_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd0) |->
        (o_req.level == $past(line_zero_level_field)))
        else $error("line 0 level wrong");
    line1_level_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd1) |->
        (o_req.level == $past(line_one_level_field)))
        else $error("line 1 level wrong");
    line2_level_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd2) |->
        (o_req.level == $past(line_two_level_field)))
        else $error("line 2 level wrong");
    line5_level_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd5) |->
        (o_req.level == $past(line_five_level_field)))
        else $error("line 5 level wrong");
    line6_level_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_req.valid && o_req.line == 5'd6) |->
        (o_req.level == $past(line_six_level_field)))
        else $error("line 6 level wrong");

    // Lines drop when their sources drop
    ext4_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_ext_irq[4] |=> !o_lines[0])
        else $error("line 0 high without channel 4");
    ext5_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_ext_irq[5] |=> !o_lines[1])
        else $error("line 1 high without channel 5");
    ext26_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !(i_ext_irq[2] || i_ext_irq[6]) |=> !o_lines[2])
        else $error("line 2 high without channel 2 or 6");
    tmr_lo_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_tmr0_lo_irq |=> !o_lines[5])
        else $error("line 5 high without timer lower half");
    tmr_hi_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_tmr0_hi_irq |=> !o_lines[6])
        else $error("line 6 high without timer upper half");
endmodule
`default_nettype wire

// ===== verification/vism_cpu_model.sv
`default_nettype none
module vism_cpu_model
    import vism_pkg::*;
(
    input wire logic i_ref_clk,
    input wire vism_pkg::vism_req_t i_req,
    output logic [15:0] o_fetch_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Core fetches the vector of the winning line
    always_ff @(posedge i_ref_clk) begin
        if (i_req.valid) begin
            o_fetch_addr <= i_req.vec_upper;
        end
    end
endmodule
`default_nettype wire

// ===== verification/vism_irq_map_bench.sv
`default_nettype none
module vism_irq_map_bench;
    import vism_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] ext;
        logic lo;
        logic hi;
        logic [23:0] oth;
        logic [47:0] lvl;
        logic [4:0] ln;
    } vism_row_t;
    localparam logic [47:0] F = 48'hFFFF_FFFF_FFFF;
    // Line 1F means no request expected
    localparam vism_row_t rows[12] = '{'{8'h10, 1'h0, 1'h0, 24'h0, F, 5'h00},
        '{8'h20, 1'h0, 1'h0, 24'h0, F, 5'h01},
        '{8'h04, 1'h0, 1'h0, 24'h0, F, 5'h02},
        '{8'h40, 1'h0, 1'h0, 24'h0, F, 5'h02},
        '{8'h08, 1'h0, 1'h0, 24'h0, F, 5'h03},
        '{8'h80, 1'h0, 1'h0, 24'h0, F, 5'h03},
        '{8'h00, 1'h1, 1'h0, 24'h0, F, 5'h05},
        '{8'h00, 1'h0, 1'h1, 24'h0, F, 5'h06},
        '{8'h20, 1'h0, 1'h1, 24'h0, F, 5'h01},
        '{8'h20, 1'h0, 1'h1, 24'h0, 48'hFFFF_FFFF_CFFF, 5'h06},
        '{8'h00, 1'h0, 1'h0, 24'h6F, F, 5'h1F},
        '{8'h00, 1'h0, 1'h0, 24'h800010, F, 5'h04}};
    logic clk = 1'b0, srst = 1'b1, lo = 1'b0, hi = 1'b0;
    logic [7:0] ext = 8'h00;
    logic [23:0] oth = 24'h0, lines;
    logic [47:0] lvl = F;
    logic [15:0] up, fetch;
    vism_req_t req;
    int n_fail = 0, comparisons = 0;
    always #4 clk = ~clk;
    vism_irq_map i_vism_irq_map(.i_ref_clk(clk), .i_srst(srst),
        .i_ext_irq(ext), .i_tmr0_lo_irq(lo), .i_tmr0_hi_irq(hi),
        .i_other_irq(oth), .i_level_fields(lvl), .o_lines(lines),
        .o_req(req));
    vism_cpu_model i_vism_cpu_model(.i_ref_clk(clk), .i_req(req),
        .o_fetch_addr(fetch));
    task automatic test_done();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input vism_req_t e);
        comparisons++;
        if (req !== e) begin
            n_fail++;
            $display("[FAIL] o_req exp %h got %h", e, req);
        end
    endtask
    task automatic chk_lines(input logic [23:0] e);
        comparisons++;
        if (lines !== e) begin
            n_fail++;
            $display("[FAIL] o_lines exp %h got %h", e, lines);
        end
    endtask
    task automatic chk_fetch(input logic [15:0] e);
        comparisons++;
        if (fetch !== e) begin
            n_fail++;
            $display("[FAIL] fetch_addr exp %h got %h", e, fetch);
        end
    endtask
    task automatic run(input vism_row_t r);
        logic [23:0] el;
        @(negedge clk);
        {ext, lo, hi, oth, lvl} = {r.ext, r.lo, r.hi, r.oth, r.lvl};
        el = r.oth;
        el[0] = r.ext[4];
        el[1] = r.ext[5];
        el[2] = r.ext[2] | r.ext[6];
        el[3] = r.ext[3] | r.ext[7];
        el[5] = r.lo;
        el[6] = r.hi;
        up = 16'hFFFA - 16'(2 * r.ln);
        @(negedge clk);
        chk_lines(el);
        @(negedge clk);
        if (r.ln == 5'h1F) chk('0);
        else chk({1'h1, r.ln, r.lvl[2*r.ln+:2], up, up + 16'h1});
        if (r.ln != 5'h1F) begin
            @(negedge clk);
            chk_fetch(up);
        end
    endtask
    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk('0);
        foreach (rows[k]) run(rows[k]);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        chk('0);
        chk_lines(24'h0);
        srst = 1'b0;
        run(rows[11]);
        test_done();
    end
    initial begin
        #2000;
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
